// ===== rtl/qer_pkg.sv
// Constants and types shared by the quadrature encoder rescaler.
package qer_pkg;

    // ------------------------------------------------------------
    // Widths, limits and reset values
    // ------------------------------------------------------------
    localparam int          FACTOR_W      = 8;      // Width of the rate factors.
    localparam int          BACK_W        = 9;      // Width of the reverse step counter.
    localparam int          PEND_W        = 16;     // Width of the multiplier backlog.
    localparam int          PIN_W         = 3;      // Input pins one, two and four.
    localparam logic [8:0]  BACK_MAX      = 9'h100; // Reverse steps tolerated, saturation.
    localparam logic [8:0]  BACK_RST      = 9'h000;
    localparam logic [15:0] PEND_MAX      = 16'hFFFF;
    localparam logic [15:0] PEND_RST      = 16'h0000;
    localparam logic [7:0]  DIV_RST       = 8'h00;
    localparam logic [2:0]  SYNC_RST      = 3'h0;

    // ------------------------------------------------------------
    // Configuration encodings
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        QER_POSITION = 1'b0,  // Reverse tracking, output only when net forward.
        QER_MOTION   = 1'b1   // Pulse on every step in either direction.
    } qer_cond_e;

    typedef enum logic [0:0] {
        QER_B_LEADS_FORWARD = 1'b0,
        QER_A_LEADS_FORWARD = 1'b1
    } qer_sense_e;

    typedef enum logic [0:0] {
        QER_A_PIN_ONE = 1'b0
    } qer_asel_e;

    typedef enum logic [1:0] {
        QER_B_GROUNDED = 2'b00,
        QER_B_PIN_TWO  = 2'b01,
        QER_B_PIN_FOUR = 2'b10
    } qer_bsel_e;

    typedef enum logic [0:0] {
        QER_RISING = 1'b0,
        QER_ANY    = 1'b1
    } qer_edge_e;

    typedef enum logic [0:0] {
        QER_MUL_THEN_DIV = 1'b0,
        QER_DIV_THEN_MUL = 1'b1
    } qer_order_e;

endpackage

// ===== rtl/qer_scale_if.sv
// Step pulses and rescaler settings passed from the decoder to the rescaler.
interface qer_scale_if;
    logic                         step;        // One-cycle step to rescale.
    logic [qer_pkg::FACTOR_W-1:0] mul_factor;  // Pulses out per step.
    logic [qer_pkg::FACTOR_W-1:0] div_factor;  // Steps in per pulse.
    qer_pkg::qer_order_e          order;       // Stage order.
    logic                         pulse;       // One-cycle rescaled pulse.

    modport decoder (output step, mul_factor, div_factor, order, input pulse);
    modport scaler  (input step, mul_factor, div_factor, order, output pulse);
endinterface

// ===== rtl/qer_rescale.sv
// Rate multiplier and divider with selectable order.
module qer_rescale (
    input  wire logic       core_clk_i,  // System clock.
    input  wire logic       reset_i,     // Asynchronous reset, active high.
    qer_scale_if.scaler     sc           // Steps in, pulses out.
);

    logic [qer_pkg::PEND_W-1:0]   pend_reg;
    logic [qer_pkg::PEND_W-1:0]   pend_next;
    logic [qer_pkg::FACTOR_W-1:0] div_cnt_reg;
    logic [qer_pkg::FACTOR_W-1:0] div_cnt_next;
    logic [qer_pkg::FACTOR_W-1:0] mul_eff;
    logic [qer_pkg::FACTOR_W-1:0] div_eff;
    logic                         mul_in;
    logic                         mul_out;
    logic                         div_in;
    logic                         div_out;

    // ------------------------------------------------------------
    // Stage routing
    // ------------------------------------------------------------
    // A zero factor behaves as one so a cleared setting never stops the line.
    assign mul_eff  = (sc.mul_factor == '0) ? 8'h01 : sc.mul_factor;
    assign div_eff  = (sc.div_factor == '0) ? 8'h01 : sc.div_factor;
    // The multiplier output is registered, so chaining either way has no loop.
    assign mul_out  = (pend_reg != '0);
    assign mul_in   = (sc.order == qer_pkg::QER_MUL_THEN_DIV) ? sc.step : div_out;
    assign div_in   = (sc.order == qer_pkg::QER_MUL_THEN_DIV) ? mul_out : sc.step;
    assign div_out  = div_in && (div_cnt_reg == div_eff - 8'h01);
    assign sc.pulse = (sc.order == qer_pkg::QER_MUL_THEN_DIV) ? div_out : mul_out;

    // Multiplier backlog: each multiplier input (mul_in) adds the factor, one pulse drains per cycle.
    // Steps faster than the drain rate pile up and saturate rather than wrap.
    always_comb begin
        logic [qer_pkg::PEND_W:0] sum;
        sum = {1'b0, pend_reg} - {{qer_pkg::PEND_W{1'b0}}, mul_out}
            + (mul_in ? {{(qer_pkg::PEND_W + 1 - qer_pkg::FACTOR_W){1'b0}}, mul_eff}
                      : {(qer_pkg::PEND_W + 1){1'b0}});
        pend_next = sum[qer_pkg::PEND_W] ? qer_pkg::PEND_MAX : sum[qer_pkg::PEND_W-1:0];
    end

    // Divider: counts input steps and releases one pulse every div_eff steps.
    always_comb begin
        div_cnt_next = div_cnt_reg;
        if (div_out) begin
            div_cnt_next = '0;
        end else if (div_in) begin
            div_cnt_next = div_cnt_reg + 8'h01;
        end
    end

    // Register the stage state.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_reg    <= qer_pkg::PEND_RST;
            div_cnt_reg <= qer_pkg::DIV_RST;
        end else begin
            pend_reg    <= pend_next;
            div_cnt_reg <= div_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_MUL_LOAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        mul_in && pend_reg == '0 |=> pend_reg == {8'h00, $past(mul_eff)})
        else $error("Multiplier backlog not loaded with the factor.");
    AST_DIV_PERIOD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        div_out |-> div_in && div_cnt_reg == div_eff - 8'h01 ##1 div_cnt_reg == '0)
        else $error("Divider released a pulse at the wrong count.");
    AST_ORDER_DM: assert property (@(posedge core_clk_i) disable iff (reset_i)
        sc.order == qer_pkg::QER_DIV_THEN_MUL && sc.step && div_eff == 8'h01
        && pend_reg == '0 && sc.order == $past(sc.order) |=> sc.pulse)
        else $error("Divide-first order did not pass a pulse.");
    COV_MUL_BURST: cover property (@(posedge core_clk_i) disable iff (reset_i)
        sc.pulse [*3]);
    COV_DIV_WRAP: cover property (@(posedge core_clk_i) disable iff (reset_i)
        div_out && div_eff > 8'h02);

endmodule

// ===== rtl/qer_top.sv
// Quadrature encoder front end: pin selection, direction, reverse tracking and rescaling.

module qer_top (
    input  wire logic                         core_clk_i,           // System clock, 100 MHz.
    input  wire logic                         reset_i,              // Async reset, high.
    input  wire logic                         input_pin_one_i,      // Physical input pin one.
    input  wire logic                         input_pin_two_i,      // Physical input pin two.
    input  wire logic                         input_pin_four_i,     // Physical input pin four.
    input  wire qer_pkg::qer_cond_e           enc_output_condition_i, // Position or motion.
    input  wire qer_pkg::qer_sense_e          enc_forward_sense_i,  // Which phase leads forward.
    input  wire qer_pkg::qer_asel_e           phase_a_select_i,     // Phase A source.
    input  wire qer_pkg::qer_bsel_e           phase_b_select_i,     // Phase B source.
    input  wire qer_pkg::qer_edge_e           enc_edge_select_i,    // Rising or any edge.
    input  wire qer_pkg::qer_order_e          rescale_sequence_i,   // Stage order.
    input  wire logic [qer_pkg::FACTOR_W-1:0] rate_mul_factor_i,    // Multiplier, 0 acts as 1.
    input  wire logic [qer_pkg::FACTOR_W-1:0] rate_div_factor_i,    // Divider, 0 acts as 1.
    output logic                              enc_pulse_o,          // Registered output pulse.
    output logic                              enc_forward_o,        // Direction of last step.
    output logic [qer_pkg::BACK_W-1:0]        back_count_o          // Reverse steps pending.
);

    logic [qer_pkg::PIN_W-1:0]  sync1_reg;
    logic [qer_pkg::PIN_W-1:0]  sync2_reg;
    logic                       phase_a_reg;
    logic                       phase_a_next;
    logic                       phase_a;
    logic                       phase_b;
    logic                       a_edge;
    logic                       step_evt;
    logic                       fwd;
    logic                       keep_step;
    logic [qer_pkg::BACK_W-1:0] back_reg;
    logic [qer_pkg::BACK_W-1:0] back_next;
    logic                       fwd_reg;
    logic                       fwd_next;
    logic                       pulse_reg;
    logic                       pulse_next;

    qer_scale_if sc ();

    // ------------------------------------------------------------
    // Input synchronisers and phase selection
    // ------------------------------------------------------------
    // Encoder lines are asynchronous; the first stage is read only by the second.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= qer_pkg::SYNC_RST;
            sync2_reg <= qer_pkg::SYNC_RST;
        end else begin
            sync1_reg <= {input_pin_four_i, input_pin_two_i, input_pin_one_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Phase A has a single source; any other code leaves phase A idle.
    assign phase_a = (phase_a_select_i == qer_pkg::QER_A_PIN_ONE) && sync2_reg[0];

    // Phase B source selection; grounded reads as low.
    always_comb begin
        case (phase_b_select_i)
            qer_pkg::QER_B_PIN_TWO:  phase_b = sync2_reg[1];
            qer_pkg::QER_B_PIN_FOUR: phase_b = sync2_reg[2];
            default:                 phase_b = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Edge detection and direction
    // ------------------------------------------------------------
    assign phase_a_next = phase_a;
    assign a_edge       = phase_a != phase_a_reg;
    // Only phase A edges count, so one step per A edge and rate halves on rising only.
    assign step_evt     = a_edge && (enc_edge_select_i == qer_pkg::QER_ANY || phase_a);

    // After an A edge, B equal to A means B moved first and so leads.
    always_comb begin
        if (phase_b_select_i == qer_pkg::QER_B_GROUNDED) begin
            fwd = 1'b1;
        end else if (enc_forward_sense_i == qer_pkg::QER_B_LEADS_FORWARD) begin
            fwd = (phase_a == phase_b);
        end else begin
            fwd = (phase_a != phase_b);
        end
    end

    // ------------------------------------------------------------
    // Output condition and reverse tracking
    // ------------------------------------------------------------
    // The counter holds 256 reverse steps; beyond that it sticks, so the
    // position is lost and exactly 256 forward steps are swallowed afterwards.
    always_comb begin
        back_next = back_reg;
        keep_step = 1'b0;
        fwd_next  = fwd_reg;
        if (step_evt) begin
            fwd_next = fwd;
            if (enc_output_condition_i == qer_pkg::QER_MOTION) begin
                keep_step = 1'b1;
            end else if (!fwd) begin
                if (back_reg != qer_pkg::BACK_MAX) begin
                    back_next = back_reg + 9'h001;
                end
            end else if (back_reg != '0) begin
                back_next = back_reg - 9'h001;
            end else begin
                keep_step = 1'b1;
            end
        end
    end

    assign sc.step       = keep_step;
    assign sc.mul_factor = rate_mul_factor_i;
    assign sc.div_factor = rate_div_factor_i;
    assign sc.order      = rescale_sequence_i;
    assign pulse_next    = sc.pulse;

    qer_rescale u_rescale (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .sc         (sc)
    );

    // Register decoder state and the output pulse.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_a_reg <= 1'b0;
            back_reg    <= qer_pkg::BACK_RST;
            fwd_reg     <= 1'b1;
            pulse_reg   <= 1'b0;
        end else begin
            phase_a_reg <= phase_a_next;
            back_reg    <= back_next;
            fwd_reg     <= fwd_next;
            pulse_reg   <= pulse_next;
        end
    end

    assign enc_pulse_o   = pulse_reg;
    assign enc_forward_o = fwd_reg;
    assign back_count_o  = back_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // The synchroniser holds reset values for a few edges after release, so skip those.
    AST_SYNC_LAT: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3)
        && phase_a_select_i == qer_pkg::QER_A_PIN_ONE
        && $past(phase_a_select_i) == qer_pkg::QER_A_PIN_ONE
        |-> phase_a_reg == $past(input_pin_one_i, 3))
        else $error("Phase A not delayed by the synchroniser.");
    AST_PIN_FOUR: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && !$past(reset_i, 2)
        && phase_b_select_i == qer_pkg::QER_B_PIN_FOUR
        |-> phase_b == $past(input_pin_four_i, 2))
        else $error("Phase B not taken from input pin four.");
    AST_RISE_ONLY: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enc_edge_select_i == qer_pkg::QER_RISING && step_evt |-> phase_a && !phase_a_reg)
        else $error("Step taken on a falling edge in rising mode.");
    AST_GND_FWD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        phase_b_select_i == qer_pkg::QER_B_GROUNDED && step_evt |=> fwd_reg)
        else $error("Grounded phase B gave a reverse step.");
    AST_B_LEAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        phase_b_select_i != qer_pkg::QER_B_GROUNDED && step_evt
        && enc_forward_sense_i == qer_pkg::QER_B_LEADS_FORWARD
        |=> fwd_reg == $past(phase_a == phase_b))
        else $error("B-leads direction decoded wrongly.");
    AST_A_LEAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        phase_b_select_i != qer_pkg::QER_B_GROUNDED && step_evt
        && enc_forward_sense_i == qer_pkg::QER_A_LEADS_FORWARD
        |=> fwd_reg == $past(phase_a != phase_b))
        else $error("A-leads direction decoded wrongly.");
    AST_MOTION_ALL: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enc_output_condition_i == qer_pkg::QER_MOTION && step_evt
        |-> keep_step ##1 back_reg == $past(back_reg))
        else $error("Motion mode dropped a step.");
    AST_BEHIND_MUTE: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enc_output_condition_i == qer_pkg::QER_POSITION && back_reg != '0 |-> !keep_step)
        else $error("Output produced while behind in position mode.");
    AST_BACK_SAT: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enc_output_condition_i == qer_pkg::QER_POSITION && back_reg == qer_pkg::BACK_MAX
        && step_evt && !fwd |=> back_reg == qer_pkg::BACK_MAX)
        else $error("Reverse counter did not hold at its maximum.");
    AST_DROP: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enc_output_condition_i == qer_pkg::QER_POSITION && step_evt && fwd && back_reg != '0
        |=> back_reg == $past(back_reg) - 9'h001)
        else $error("Forward step did not retire a reverse step.");
    AST_COND_SEL: assert property (@(posedge core_clk_i) disable iff (reset_i)
        keep_step == (step_evt && (enc_output_condition_i == qer_pkg::QER_MOTION
                                   || (fwd && back_reg == '0))))
        else $error("Output step does not match the output condition.");
    COV_SATURATE: cover property (@(posedge core_clk_i) disable iff (reset_i)
        back_reg == qer_pkg::BACK_MAX && step_evt && !fwd);
    COV_RESUME: cover property (@(posedge core_clk_i) disable iff (reset_i)
        back_reg == 9'h001 && step_evt && fwd ##[1:64] keep_step);

endmodule

// ===== testbench/qer_encoder_model.sv
// Behavioural quadrature shaft encoder that drives the three input pins.
module qer_encoder_model (
    input  wire logic               core_clk_i,  // Bench clock.
    input  wire qer_pkg::qer_bsel_e b_route_i,   // Pin that carries phase B.
    output logic                    pin_one_o,   // Phase A.
    output logic                    pin_two_o,   // Phase B or noise.
    output logic                    pin_four_o   // Phase B or noise.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic a_q = 1'b0;
    logic b_q = 1'b0;
    logic noise_q = 1'b0;

    // Pin two or four, when it does not carry phase B, toggles every cycle, so a wrong pick shows up.
    always @(posedge core_clk_i) begin
        noise_q <= ~noise_q;
    end
    assign pin_one_o  = a_q;
    assign pin_two_o  = (b_route_i == qer_pkg::QER_B_PIN_TWO) ? b_q : noise_q;
    assign pin_four_o = (b_route_i == qer_pkg::QER_B_PIN_FOUR) ? b_q : noise_q;

    // Full quadrature cycles; each phase change holds 4 clocks, well above the decode minimum.
    task automatic move(input bit a_first, input int n);
        repeat (n) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge core_clk_i);
                if ((k[0] == 1'b0) == a_first) begin
                    a_q <= ~a_q;
                end else begin
                    b_q <= ~b_q;
                end
                repeat (3) @(posedge core_clk_i);
            end
        end
    endtask
endmodule

// ===== testbench/qer_top_tb_top.sv
// Self-checking bench for the quadrature encoder rescaler.
module qer_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic                         core_clk = 1'b0;
    logic                         reset = 1'b1;
    logic                         pin_one, pin_two, pin_four;
    qer_pkg::qer_cond_e           cond = qer_pkg::QER_MOTION;
    qer_pkg::qer_sense_e          sense = qer_pkg::QER_A_LEADS_FORWARD;
    qer_pkg::qer_asel_e           asel = qer_pkg::QER_A_PIN_ONE;
    qer_pkg::qer_bsel_e           bsel = qer_pkg::QER_B_PIN_TWO;
    qer_pkg::qer_edge_e           edge_sel = qer_pkg::QER_RISING;
    qer_pkg::qer_order_e          order = qer_pkg::QER_MUL_THEN_DIV;
    logic [qer_pkg::FACTOR_W-1:0] mul = 8'h01;
    logic [qer_pkg::FACTOR_W-1:0] div = 8'h01;
    logic                         enc_pulse, enc_forward;
    logic [qer_pkg::BACK_W-1:0]   back_count;
    int                           n_errors = 0;
    int                           comparisons = 0;
    int                           pulse_cnt = 0;
    int                           base;

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    qer_top qer_top_i (
        .core_clk_i(core_clk), .reset_i(reset), .input_pin_one_i(pin_one),
        .input_pin_two_i(pin_two), .input_pin_four_i(pin_four),
        .enc_output_condition_i(cond), .enc_forward_sense_i(sense),
        .phase_a_select_i(asel), .phase_b_select_i(bsel), .enc_edge_select_i(edge_sel),
        .rescale_sequence_i(order), .rate_mul_factor_i(mul), .rate_div_factor_i(div),
        .enc_pulse_o(enc_pulse), .enc_forward_o(enc_forward), .back_count_o(back_count));

    qer_encoder_model qer_encoder_model_i (
        .core_clk_i(core_clk), .b_route_i(bsel), .pin_one_o(pin_one),
        .pin_two_o(pin_two), .pin_four_o(pin_four));

    // Pulses are counted continuously; tests compare differences to stay independent.
    always @(posedge core_clk) begin
        if (enc_pulse === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic set_cfg(input qer_pkg::qer_cond_e c, input qer_pkg::qer_sense_e s,
                           input qer_pkg::qer_bsel_e b, input qer_pkg::qer_edge_e e);
        @(posedge core_clk);
        cond     <= c;
        sense    <= s;
        bsel     <= b;
        edge_sel <= e;
        repeat (2) @(posedge core_clk);
    endtask

    // Moves the encoder, lets the backlog drain, then checks pulses, direction and debt.
    task automatic run(input string name, input bit a_first, input int n, input int exp_p,
                       input logic exp_f, input logic [8:0] exp_b);
        base = pulse_cnt;
        qer_encoder_model_i.move(a_first, n);
        repeat (24) @(posedge core_clk);
        chk("pulses", 16'(exp_p), 16'(pulse_cnt - base));
        chk("forward", {15'h0000, exp_f}, {15'h0000, enc_forward});
        chk("back_count", {7'h00, exp_b}, {7'h00, back_count});
        $display("test %s done", name);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    logic [7:0]          t_mul [5] = '{8'h03, 8'h01, 8'h03, 8'h03, 8'h02};
    logic [7:0]          t_div [5] = '{8'h01, 8'h04, 8'h02, 8'h02, 8'h01};
    qer_pkg::qer_order_e t_ord [5] = '{qer_pkg::QER_MUL_THEN_DIV, qer_pkg::QER_MUL_THEN_DIV,
                                       qer_pkg::QER_MUL_THEN_DIV, qer_pkg::QER_DIV_THEN_MUL,
                                       qer_pkg::QER_DIV_THEN_MUL};
    int                  t_n   [5] = '{2, 8, 3, 3, 2};
    int                  t_exp [5] = '{6, 2, 4, 3, 4};

    initial begin
        do_reset();
        base = pulse_cnt;
        fork
            qer_encoder_model_i.move(1'b1, 1);
            begin
                // A pulse counted by now would mean the pins skipped a synchroniser stage.
                repeat (6) @(posedge core_clk);
                chk("early pulse", 16'h0000, 16'(pulse_cnt - base));
            end
        join
        repeat (8) @(posedge core_clk);
        chk("first pulse", 16'h0001, 16'(pulse_cnt - base));
        $display("test first pulse done");
        run("motion forward", 1'b1, 4, 4, 1'b1, 9'h000);
        run("motion reverse", 1'b0, 3, 3, 1'b0, 9'h000);
        set_cfg(qer_pkg::QER_MOTION, qer_pkg::QER_A_LEADS_FORWARD, qer_pkg::QER_B_PIN_TWO,
                qer_pkg::QER_ANY);
        run("any edge", 1'b1, 2, 4, 1'b1, 9'h000);
        set_cfg(qer_pkg::QER_MOTION, qer_pkg::QER_B_LEADS_FORWARD, qer_pkg::QER_B_PIN_FOUR,
                qer_pkg::QER_RISING);
        run("b leads fwd", 1'b0, 2, 2, 1'b1, 9'h000);
        run("b leads rev", 1'b1, 1, 1, 1'b0, 9'h000);
        set_cfg(qer_pkg::QER_POSITION, qer_pkg::QER_A_LEADS_FORWARD, qer_pkg::QER_B_GROUNDED,
                qer_pkg::QER_RISING);
        run("b grounded", 1'b0, 3, 3, 1'b1, 9'h000);
        set_cfg(qer_pkg::QER_POSITION, qer_pkg::QER_A_LEADS_FORWARD, qer_pkg::QER_B_PIN_TWO,
                qer_pkg::QER_RISING);
        run("position back", 1'b0, 5, 0, 1'b0, 9'h005);
        run("position repay", 1'b1, 5, 0, 1'b1, 9'h000);
        run("position ahead", 1'b1, 3, 3, 1'b1, 9'h000);
        set_cfg(qer_pkg::QER_POSITION, qer_pkg::QER_A_LEADS_FORWARD, qer_pkg::QER_B_PIN_TWO,
                qer_pkg::QER_ANY);
        run("saturate", 1'b0, 150, 0, 1'b0, 9'h100);
        run("drop after sat", 1'b1, 128, 0, 1'b1, 9'h000);
        run("resume after sat", 1'b1, 2, 4, 1'b1, 9'h000);
        set_cfg(qer_pkg::QER_MOTION, qer_pkg::QER_A_LEADS_FORWARD, qer_pkg::QER_B_PIN_TWO,
                qer_pkg::QER_RISING);
        // Reset before each case so no divider remainder leaks between them.
        for (int i = 0; i < 5; i++) begin
            mul   <= t_mul[i];
            div   <= t_div[i];
            order <= t_ord[i];
            do_reset();
            run("rescale", 1'b1, t_n[i], t_exp[i], 1'b1, 9'h000);
        end
        end_sim();
    end
endmodule
